// ===== src/flash_pe_pkg.sv
package flash_pe_pkg;
  localparam logic [3:0] ADDR_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_PROGRAM_SELECT = 4'h1;
  localparam logic [3:0] ADDR_ERASE_SELECT = 4'h2;
  localparam logic [3:0] ADDR_UNLOCK_KEY = 4'h3;
  localparam logic [3:0] ADDR_ARRAY_SELECT = 4'h4;
  localparam logic [3:0] ADDR_TRANSFER_DEST = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_MODE_STATUS = 4'h8;
  localparam int BIT_RES7 = 7;
  localparam int BIT_ERROR = 4;
  localparam int BIT_DOWNLOAD = 0;
  localparam logic [7:0] CONTROL_STATUS_RESET = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hA5;
  localparam int IRQ_ERROR = 0;
  localparam int IRQ_DOWNLOAD_DONE = 1;
  localparam int CLOCK_MHZ = 25;
  localparam int DOWNLOAD_NS = 4000;
  localparam int DOWNLOAD_CYCLES = (DOWNLOAD_NS * CLOCK_MHZ) / 1000;
  typedef enum logic [1:0] {
    DL_IDLE = 2'b01,
    DL_BUSY = 2'b10
  } download_state_t;
endpackage

// ===== src/flash_prog_erase_ctrl_regs.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module flash_prog_erase_ctrl_regs #(
  parameter int DownloadCycles = flash_pe_pkg::DOWNLOAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic flashAccessEnable,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic progEraseActive,
  input wire logic irqDuringOp,
  input wire logic flashReadDuringOp,
  input wire logic sleepDuringOp,
  input wire logic otherMasterDuringOp,
  input wire logic modeSelectHi,
  input wire logic modeSelectLo,
  input wire logic bootSerialRx,
  input wire logic linkTxData,
  output logic bootSerialTx,
  output logic linkRxData,
  output logic bootMode,
  output logic errorProtect,
  output logic downloadActive,
  output logic [7:0] programRoutineSelect,
  output logic [7:0] eraseRoutineSelect,
  output logic [7:0] memoryArraySelect,
  output logic [7:0] transferDestinationAddr,
  output logic irq
);
  import flash_pe_pkg::*;

  localparam int CntW = $clog2(DownloadCycles + 1);

  logic [1:0] modeHiSync;
  logic [1:0] modeLoSync;
  logic [1:0] rxSync;
  logic [1:0] enSync;
  logic errorFlag_reg;
  logic [7:0] unlockKey_reg;
  logic [1:0] irqStatus_reg;
  logic [1:0] irqMask_reg;
  download_state_t dlState_reg;
  logic [CntW-1:0] dlCount_reg;
  logic accessOk;
  logic wrHit;
  logic errorEvent;
  logic dlStart;
  logic dlDone;
  logic [7:0] readMux;

  // Mode, receive and enable pins are synchronized; access gating uses the raw enable pin
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeHiSync <= 2'h0;
      modeLoSync <= 2'h0;
      rxSync <= 2'h3;
      enSync <= 2'h0;
    end
    else if (clkEn)
    begin
      modeHiSync <= {modeHiSync[0], modeSelectHi};
      modeLoSync <= {modeLoSync[0], modeSelectLo};
      rxSync <= {rxSync[0], bootSerialRx};
      enSync <= {enSync[0], flashAccessEnable};
    end
  end

  assign accessOk = flashAccessEnable;
  assign wrHit = regWrStb && accessOk;
  assign errorEvent = progEraseActive &&
    (irqDuringOp || flashReadDuringOp || sleepDuringOp || otherMasterDuringOp);
  assign dlStart = wrHit && (regAddr == ADDR_CONTROL_STATUS) && regWrData[BIT_DOWNLOAD]
    && (unlockKey_reg == UNLOCK_KEY_VALUE) && (dlState_reg == DL_IDLE);
  assign dlDone = (dlState_reg == DL_BUSY) && (dlCount_reg == CntW'(1));

  // Error flag: only a power-on reset clears it
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      errorFlag_reg <= CONTROL_STATUS_RESET[BIT_ERROR];
    else if (clkEn && errorEvent)
      errorFlag_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dlState_reg <= DL_IDLE;
      dlCount_reg <= '0;
    end
    else if (clkEn)
    begin
      unique case (dlState_reg)
        DL_IDLE:
        begin
          if (dlStart)
          begin
            dlState_reg <= DL_BUSY;
            dlCount_reg <= CntW'(DownloadCycles);
          end
        end
        DL_BUSY:
        begin
          dlCount_reg <= dlCount_reg - CntW'(1);
          if (dlDone)
            dlState_reg <= DL_IDLE;
        end
        default:
          dlState_reg <= DL_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      unlockKey_reg <= REG_RESET;
      programRoutineSelect <= REG_RESET;
      eraseRoutineSelect <= REG_RESET;
      memoryArraySelect <= REG_RESET;
      transferDestinationAddr <= REG_RESET;
      irqMask_reg <= 2'h0;
    end
    else if (clkEn && wrHit)
    begin
      unique case (regAddr)
        ADDR_UNLOCK_KEY: unlockKey_reg <= regWrData;
        ADDR_PROGRAM_SELECT: programRoutineSelect <= regWrData;
        ADDR_ERASE_SELECT: eraseRoutineSelect <= regWrData;
        ADDR_ARRAY_SELECT: memoryArraySelect <= regWrData;
        ADDR_TRANSFER_DEST: transferDestinationAddr <= regWrData;
        ADDR_IRQ_MASK: irqMask_reg <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqStatus_reg <= 2'h0;
    else if (clkEn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_ERROR && errorEvent) || (i == IRQ_DOWNLOAD_DONE && dlDone))
          irqStatus_reg[i] <= 1'b1;
        else if (wrHit && regAddr == ADDR_IRQ_STATUS && regWrData[i])
          irqStatus_reg[i] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    readMux = 8'h00;
    unique case (regAddr)
      ADDR_CONTROL_STATUS:
      begin
        readMux[BIT_RES7] = CONTROL_STATUS_RESET[BIT_RES7];
        readMux[BIT_ERROR] = errorFlag_reg;
        readMux[BIT_DOWNLOAD] = (dlState_reg == DL_BUSY);
      end
      ADDR_PROGRAM_SELECT: readMux = programRoutineSelect;
      ADDR_ERASE_SELECT: readMux = eraseRoutineSelect;
      ADDR_UNLOCK_KEY: readMux = unlockKey_reg;
      ADDR_ARRAY_SELECT: readMux = memoryArraySelect;
      ADDR_TRANSFER_DEST: readMux = transferDestinationAddr;
      ADDR_IRQ_STATUS: readMux = {6'h00, irqStatus_reg};
      ADDR_IRQ_MASK: readMux = {6'h00, irqMask_reg};
      ADDR_MODE_STATUS: readMux = {5'h00, enSync[1], modeHiSync[1], modeLoSync[1]};
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdData <= 8'h00;
      bootMode <= 1'b0;
      bootSerialTx <= 1'b1;
      linkRxData <= 1'b1;
      errorProtect <= 1'b0;
      downloadActive <= 1'b0;
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      // Closed window reads zero rather than stale data
      regRdData <= (regRdStb && accessOk) ? readMux : 8'h00;
      // Mode 10 treated as boot mode here
      bootMode <= modeHiSync[1] && !modeLoSync[1];
      bootSerialTx <= (modeHiSync[1] && !modeLoSync[1]) ? linkTxData : 1'b1;
      linkRxData <= rxSync[1];
      errorProtect <= errorFlag_reg || errorEvent;
      downloadActive <= (dlState_reg == DL_BUSY) || dlStart;
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  a_error_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    errorFlag_reg |=> errorFlag_reg) else $error("error flag dropped");
  a_error_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && errorEvent) |=> errorFlag_reg) else $error("error not set");
  a_protect_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && errorFlag_reg) |=> errorProtect) else $error("protect missing");
  sequence dlKick;
    clkEn && dlStart;
  endsequence
  a_download_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dlKick |=> (dlState_reg == DL_BUSY)) else $error("download not busy");
  a_download_ends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && dlDone) |=> (dlState_reg == DL_IDLE)) else $error("request not cleared");
  a_no_key_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (unlockKey_reg != UNLOCK_KEY_VALUE) |-> !dlStart) else $error("start without key");
  a_locked_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && regRdStb && !accessOk) |=> (regRdData == 8'h00)) else $error("locked read");
  a_reserved_bits: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && regRdStb && accessOk && regAddr == ADDR_CONTROL_STATUS)
    |=> (regRdData[7:5] == 3'b100)) else $error("reserved bits wrong");

  // Read data stands one cycle, then falls back to zero
  sequence rdIdle;
    clkEn && !regRdStb;
  endsequence
  a_read_drops: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rdIdle |=> (regRdData == 8'h00)) else $error("read data held");

  // Closed window must leave the select, destination and key registers untouched
  sequence wrClosed;
    clkEn && regWrStb && !accessOk;
  endsequence
  a_closed_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrClosed |=> ($stable(transferDestinationAddr) && $stable(programRoutineSelect)
    && $stable(eraseRoutineSelect) && $stable(memoryArraySelect)))
    else $error("closed write landed");
  a_closed_key: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrClosed |=> $stable(unlockKey_reg)) else $error("closed key write landed");

  sequence csRead;
    clkEn && regRdStb && accessOk && (regAddr == ADDR_CONTROL_STATUS);
  endsequence
  a_control_zeros: assert property (@(posedge ref_clk) disable iff (!rst_b)
    csRead |=> (regRdData[3:1] == 3'b000)) else $error("control low bits set");
  a_error_visible: assert property (@(posedge ref_clk) disable iff (!rst_b)
    csRead ##0 errorFlag_reg |=> regRdData[BIT_ERROR]) else $error("error bit hidden");
  a_busy_visible: assert property (@(posedge ref_clk) disable iff (!rst_b)
    csRead ##0 (dlState_reg == DL_BUSY) |=> regRdData[BIT_DOWNLOAD])
    else $error("busy bit hidden");
  a_idle_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    csRead ##0 (dlState_reg == DL_IDLE) |=> !regRdData[BIT_DOWNLOAD])
    else $error("request bit stuck");
  a_busy_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && (dlState_reg == DL_BUSY) && !dlDone) |=> (dlState_reg == DL_BUSY))
    else $error("download cut short");

  // Protection only while the flag or a fresh event is present
  a_protect_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && !errorFlag_reg && !errorEvent) |=> !errorProtect)
    else $error("protect without error");
  a_boot_idle_tx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !bootMode |-> bootSerialTx) else $error("serial out driven outside boot");
  a_error_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && errorEvent) |=> irqStatus_reg[IRQ_ERROR]) else $error("error status lost");
  a_done_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && dlDone) |=> irqStatus_reg[IRQ_DOWNLOAD_DONE]) else $error("done status lost");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clkEn && |(irqStatus_reg & irqMask_reg)) |=> irq) else $error("irq not raised");
  // Frozen clock enable must hold the error flag, download state and read data
  a_frozen_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !clkEn |=> ($stable(errorFlag_reg) && $stable(dlState_reg) && $stable(regRdData)))
    else $error("state moved while frozen");
endmodule

// ===== tb/test_flash_prog_erase_ctrl_regs.sv
`timescale 1ns/1ps
module test_flash_prog_erase_ctrl_regs;
  import flash_pe_pkg::*;
  localparam int DlCycles = 3;
  // 100 us of reset at 40 ns per cycle
  localparam int ErrResetCycles = 2500;
  logic mdLo = 1'b0;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic accEn = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic peActive = 1'b0;
  logic [3:0] cause = 4'h0;
  logic mdHi = 1'b0;
  logic serRx = 1'b1;
  logic txData = 1'b0;
  logic [7:0] rdData, progSel, eraseSel, arraySel, destAddr;
  logic serTx, rxData, bootMode, errProt, dlActive, irq;
  logic [31:0] lfsr = 32'hD724;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  flash_prog_erase_ctrl_regs #(.DownloadCycles(DlCycles)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .clkEn(1'b1), .flashAccessEnable(accEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(rdData), .progEraseActive(peActive),
    .irqDuringOp(cause[0]), .flashReadDuringOp(cause[1]), .sleepDuringOp(cause[2]),
    .otherMasterDuringOp(cause[3]), .modeSelectHi(mdHi), .modeSelectLo(mdLo),
    .bootSerialRx(serRx), .linkTxData(txData), .bootSerialTx(serTx), .linkRxData(rxData),
    .bootMode(bootMode), .errorProtect(errProt), .downloadActive(dlActive),
    .programRoutineSelect(progSel), .eraseRoutineSelect(eraseSel),
    .memoryArraySelect(arraySel), .transferDestinationAddr(destAddr), .irq(irq));
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] resetVal(input logic [3:0] a);
    return (a == ADDR_CONTROL_STATUS) ? CONTROL_STATUS_RESET : (a == ADDR_MODE_STATUS) ? 8'h04 : REG_RESET;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic doReset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rdChk(input string name, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(name, e, d);
  endtask
  initial
  begin
    logic [7:0] v;
    logic [3:0] regs [4] = '{ADDR_PROGRAM_SELECT, ADDR_ERASE_SELECT, ADDR_ARRAY_SELECT,
      ADDR_TRANSFER_DEST};
    doReset(10);
    for (int a = 0; a < 16; a++)
      rdChk("reset value", a[3:0], resetVal(a[3:0]));
    for (int i = 0; i < 12; i++)
    begin
      v = rnd();
      wr(regs[i % 4], v);
      rdChk("readback", regs[i % 4], v);
    end
    chk("port", v, destAddr);
    wr(4'hC, rnd());
    rdChk("unmapped", 4'hC, 8'h00);
    wr(ADDR_CONTROL_STATUS, rnd() & 8'hFE);
    rdChk("reserved bits", ADDR_CONTROL_STATUS, 8'h80);
    accEn <= 1'b0;
    wr(ADDR_TRANSFER_DEST, ~v);
    rdChk("closed read", ADDR_TRANSFER_DEST, 8'h00);
    accEn <= 1'b1;
    rdChk("closed write", ADDR_TRANSFER_DEST, v);
    wr(ADDR_UNLOCK_KEY, 8'h5A);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    rdChk("no key", ADDR_CONTROL_STATUS, 8'h80);
    wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_VALUE);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    #1;
    chk("busy", 8'h01, {7'h0, dlActive});
    rd(ADDR_CONTROL_STATUS, v);
    chk("busy bit", 8'h81, v);
    for (int n = 0; n < 4 * DlCycles + 8 && v[0] === 1'b1; n++)
      rd(ADDR_CONTROL_STATUS, v);
    chk("done bit", 8'h80, v);
    rdChk("done status", ADDR_IRQ_STATUS, 8'h02);
    chk("masked", 8'h00, {7'h0, irq});
    wr(ADDR_IRQ_MASK, 8'h03);
    repeat (2) @(posedge ref_clk);
    chk("unmasked", 8'h01, {7'h0, irq});
    wr(ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk("cleared", 8'h00, {7'h0, irq});
    for (int c = 0; c < 4; c++)
    begin
      doReset(ErrResetCycles);
      wr(ADDR_IRQ_MASK, 8'h01);
      cause <= 4'h1 << c;
      repeat (3) @(posedge ref_clk);
      chk("idle cause", 8'h00, {7'h0, errProt});
      peActive <= 1'b1;
      @(posedge ref_clk);
      cause <= 4'h0;
      peActive <= 1'b0;
      rdChk("error flag", ADDR_CONTROL_STATUS, 8'h90);
      chk("protect", 8'h01, {7'h0, errProt});
      chk("error irq", 8'h01, {7'h0, irq});
    end
    wr(ADDR_IRQ_STATUS, 8'h01);
    rdChk("sticky flag", ADDR_CONTROL_STATUS, 8'h90);
    chk("error cleared", 8'h00, {7'h0, irq});
    doReset(ErrResetCycles);
    rdChk("flag reset", ADDR_CONTROL_STATUS, 8'h80);
    mdHi <= 1'b1;
    txData <= lfsr[3];
    serRx <= lfsr[5];
    repeat (6) @(posedge ref_clk);
    chk("boot", {6'h0, lfsr[3], 1'b1}, {6'h0, serTx, bootMode});
    chk("rx copy", {7'h0, lfsr[5]}, {7'h0, rxData});
    rdChk("mode", ADDR_MODE_STATUS, 8'h06);
    mdLo <= 1'b1;
    txData <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("not boot", 8'h02, {6'h0, serTx, bootMode});
    rdChk("mode both", ADDR_MODE_STATUS, 8'h07);
    summarize();
  end
endmodule
